// *** dv/multiqueue_flag_status_logic_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
// Checks quadrant selection and flag timing at the block's ports.
module multiqueue_flag_status_logic_sva
	import mq_flag_pkg::*;
#(
	parameter int NQ = NUM_QUEUES
) (
	// Clock and reset.
	input wire logic	i_clk_sys,
	input wire logic	i_rst_b,
	// Watched inputs.
	input wire logic	i_device_number_bit0,
	input wire logic	i_device_number_bit1,
	input wire logic	i_device_number_bit2,
	input wire logic [5:0]	i_queues_configured,
	input wire logic [mq_flag_pkg::ADDR_BITS-1:0]	i_write_queue_address,
	input wire logic	i_almost_full_quadrant_strobe,
	input wire logic [NQ-1:0]	i_almost_full_status,
	input wire logic	i_wr_en,
	input wire logic	i_end_of_packet_marker,
	input wire logic	i_rd_en,
	// Watched outputs.
	input wire logic	o_almost_empty_flag,
	input wire logic	o_packet_ready_flag,
	input wire logic [mq_flag_pkg::BUS_BITS-1:0]	o_almost_full_flag_bus,
	input wire logic	o_almost_full_flag_bus_oe,
	input wire logic [mq_flag_pkg::QUAD_BITS-1:0]	o_quadrant
);
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_b);
	logic	id_eq;	// Address names this device.
	logic	sel_ok;	// Selection for this device.
	logic	many;	// More than eight queues, so quadrants apply.
	logic [1:0]	quad_req;	// Quadrant asked for.
	logic	eop_wr;	// End marker written.
	assign id_eq = i_write_queue_address[7:5] == {i_device_number_bit2, i_device_number_bit1,
		i_device_number_bit0};
	assign sel_ok = i_almost_full_quadrant_strobe && id_eq;
	assign many = i_queues_configured > 6'h08;
	assign quad_req = i_write_queue_address[1:0];
	assign eop_wr = i_wr_en && i_end_of_packet_marker;
	// Bus driven for two cycles over steady status, so its content must be settled.
	sequence s_live;
		o_almost_full_flag_bus_oe && $past(o_almost_full_flag_bus_oe) && $stable(i_almost_full_status);
	endsequence
	property p_quad_latch;
		sel_ok && many |-> ##2 o_quadrant == $past(quad_req, 2);
	endproperty
	a_quad_latch: assert property (p_quad_latch) else $error("quadrant not taken");
	property p_quad_hold;
		!sel_ok |-> ##2 $stable(o_quadrant);
	endproperty
	a_quad_hold: assert property (p_quad_hold) else $error("quadrant moved");
	property p_af_map;
		s_live ##0 many |-> o_almost_full_flag_bus == i_almost_full_status[8*o_quadrant +: 8];
	endproperty
	a_af_map: assert property (p_af_map) else $error("quadrant content wrong");
	property p_af_few;
		s_live ##0 !many |-> o_almost_full_flag_bus == i_almost_full_status[7:0];
	endproperty
	a_af_few: assert property (p_af_few) else $error("first queues not shown");
	property p_oe_off;
		i_almost_full_quadrant_strobe && !id_eq |-> ##[1:2] !o_almost_full_flag_bus_oe;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("bus kept for other device");
	property p_ae_fall;
		$fell(o_almost_empty_flag) |-> $past(i_rd_en) || $past(i_rd_en, 2) || $past(i_rd_en, 3);
	endproperty
	a_ae_fall: assert property (p_ae_fall) else $error("empty flag fell late");
	property p_ae_rise;
		$rose(o_almost_empty_flag) |-> $past(i_wr_en, 2) || $past(i_wr_en, 3);
	endproperty
	a_ae_rise: assert property (p_ae_rise) else $error("empty flag rose late");
	property p_pr_fall;
		$fell(o_packet_ready_flag) |-> $past(eop_wr, 2) || $past(eop_wr, 3) || $past(eop_wr, 4);
	endproperty
	a_pr_fall: assert property (p_pr_fall) else $error("ready flag out of time");
	c_sel: cover property (sel_ok && many);
	c_ae: cover property ($rose(o_almost_empty_flag));
	c_pr: cover property ($fell(o_packet_ready_flag));
endmodule // multiqueue_flag_status_logic_sva
bind multiqueue_flag_status_logic multiqueue_flag_status_logic_sva #(.NQ(NQ)) u_sva (.*);
`default_nettype wire

// *** dv/multiqueue_flag_status_logic_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
// Compares a seen value with the expected one and counts both.
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin fail_count++; \
	$display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
// Drives the flag block through thresholds, packets and quadrant selection.
module multiqueue_flag_status_logic_tb;
	import mq_flag_pkg::*;
	localparam logic [2:0] DEV = 3'h3;	// Device number strapped on this part.
	logic	clk_sys, rst_b, dfs, fm, wr_en, sop, eop, rd_en, rd_sel, rsm;	// Drives.
	width_mode_t	wmode;	// Bus width setup.
	logic [5:0]	nq;	// Queues set up.
	logic [4:0]	wr_q;	// Write queue.
	logic [31:0]	st;	// Almost-full status per queue.
	logic	strobe, wsel, ae, pr, oe;	// Host and flag lines.
	logic [7:0]	addr, ae_bus, pr_bus, af_bus;	// Address and flag buses.
	logic [1:0]	quad;	// Quadrant shown.
	int	fail_count, checks_done, cyc;	// Counters.
	multiqueue_flag_status_logic dut (
		.i_clk_sys(clk_sys), .i_rst_b(rst_b), .i_ce(1'b1), .i_default_offset_select(dfs),
		.i_flag_bus_mode_select(fm), .i_width_mode(wmode), .i_queues_configured(nq),
		.i_device_number_bit0(DEV[0]), .i_device_number_bit1(DEV[1]),
		.i_device_number_bit2(DEV[2]), .i_wr_en(wr_en), .i_wr_queue(wr_q), .i_wr_select(wsel),
		.i_end_of_packet_marker(eop), .i_start_of_packet_marker(sop),
		.i_write_queue_address(addr), .i_almost_full_quadrant_strobe(strobe),
		.i_almost_full_status(st), .i_rd_en(rd_en), .i_rd_queue(5'h00), .i_rd_select(rd_sel),
		.i_received_start_marker(rsm), .o_almost_empty_flag(ae), .o_packet_ready_flag(pr),
		.o_almost_empty_flag_bus(ae_bus), .o_packet_ready_flag_bus(pr_bus),
		.o_almost_full_flag_bus(af_bus), .o_almost_full_flag_bus_oe(oe), .o_quadrant(quad)
	);
	quadrant_select_host host (.i_clk_sys(clk_sys), .o_strobe(strobe), .o_addr(addr),
		.o_wr_select(wsel));
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	// Cuts a hung run short well past the expected length.
	always @(posedge clk_sys) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic step(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	// Master reset with new straps, then read queue 0 is selected.
	task automatic reset_dut(input width_mode_t m, input logic d, input logic f,
		input logic [5:0] n);
		@(negedge clk_sys);
		rst_b = 1'b0;
		wmode = m;
		{dfs, fm, nq} = {d, f, n};
		step(12);
		rst_b = 1'b1;
		step(2);
		rd_sel = 1'b1;
		step(1);
		rd_sel = 1'b0;
	endtask
	// Writes n words to queue q with the given markers.
	task automatic fill(input logic [4:0] q, input int n, input logic s, input logic e);
		@(negedge clk_sys);
		{wr_en, wr_q, sop, eop} = {1'b1, q, s, e};
		step(n);
		{wr_en, sop, eop} = 3'h0;
	endtask
	task automatic rd(input int n, input logic m);
		@(negedge clk_sys);
		{rd_en, rsm} = {1'b1, m};
		step(n);
		{rd_en, rsm} = 2'h0;
	endtask
	// Queue 0 is shared with the read port, queue 1 is written only.
	task automatic t_thresholds();
		width_mode_t wm[6] = '{W_36_36, W_36_18, W_36_9, W_18_36, W_9_36, W_36_36};
		int ts[6] = '{10, 9, 9, 20, 40, 130};
		int tw[6] = '{9, 9, 9, 18, 36, 129};
		int rc[6] = '{1, 2, 4, 1, 1, 1};
		for (int i = 0; i < 6; i++) begin
			reset_dut(wm[i], i == 5, 1'b0, 6'h20);
			fill(5'h00, ts[i] - 1, 1'b0, 1'b0);
			fill(5'h01, tw[i] - 1, 1'b0, 1'b0);
			step(4);
			`CHK("ae below", 1'b0, ae)
			`CHK("ae bus below", 1'b0, ae_bus[1])
			fill(5'h00, 1, 1'b0, 1'b0);
			fill(5'h01, 1, 1'b0, 1'b0);
			step(4);
			`CHK("ae at level", 1'b1, ae)
			`CHK("ae bus shared", 1'b1, ae_bus[0])
			`CHK("ae bus write only", 1'b1, ae_bus[1])
			rd(rc[i], 1'b0);
			step(5);
			`CHK("ae after read", 1'b0, ae)
			`CHK("ae bus after read", 1'b0, ae_bus[0])
		end
	endtask
	task automatic t_packet();
		reset_dut(W_36_36, 1'b0, 1'b0, 6'h20);
		fill(5'h00, 1, 1'b1, 1'b0);
		step(6);
		`CHK("pr start only", 1'b1, pr)
		fill(5'h00, 1, 1'b0, 1'b1);
		step(6);
		`CHK("pr after end", 1'b0, pr)
		`CHK("pr bus after end", 1'b0, pr_bus[0])
		rd(1, 1'b1);
		step(5);
		`CHK("pr after start read", 1'b1, pr)
		`CHK("pr bus after start read", 1'b1, pr_bus[0])
	endtask
	task automatic t_quadrant();
		logic [1:0] q;
		reset_dut(W_36_36, 1'b0, 1'b0, 6'h20);
		for (int i = 0; i < 4; i++) begin
			q = 2'(i);
			host.select(DEV, {2'h0, q}, 1);
			step(3);
			`CHK("quadrant", q, quad)
			`CHK("af bus", st[8*q +: 8], af_bus)
			`CHK("af bus driven", 1'b1, oe)
		end
		host.select(DEV, 4'h7, 2);
		step(3);
		`CHK("quadrant back to back", 2'h1, quad)
		host.select(3'h5, 4'h2, 1);
		step(3);
		`CHK("quadrant other device", 2'h1, quad)
		`CHK("af bus released", 1'b0, oe)
		host.select(DEV, 4'h0, 1);
		step(3);
		`CHK("af bus taken back", 1'b1, oe)
	endtask
	task automatic t_modes();
		reset_dut(W_36_36, 1'b0, 1'b0, 6'h06);
		host.select(DEV, 4'h2, 1);
		step(3);
		`CHK("af bus few queues", st[7:0], af_bus)
		reset_dut(W_36_36, 1'b0, 1'b1, 6'h20);
		step(3);
		`CHK("af bus other mode", 1'b0, oe)
	endtask
	initial begin
		{rst_b, dfs, fm, wr_en, sop, eop, rd_en, rd_sel, rsm} = 9'h000;
		{wr_q, nq} = 11'h020;
		wmode = W_36_36;
		st = 32'hC3A5_1E78;
		t_thresholds();
		t_packet();
		t_quadrant();
		t_modes();
		print_verdict();
	end
endmodule // multiqueue_flag_status_logic_tb
`default_nettype wire

// *** dv/quadrant_select_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// Host controller making quadrant selections; it never selects a write queue meanwhile.
module quadrant_select_host
	import mq_flag_pkg::*;
(
	input wire logic	i_clk_sys,	// Write side clock.
	output var logic	o_strobe,	// Quadrant strobe.
	output var logic [mq_flag_pkg::ADDR_BITS-1:0]	o_addr,	// Write queue address.
	output var logic	o_wr_select	// Write queue selection, kept low.
);
	initial begin
		o_strobe = 1'b0;
		o_addr = 8'h00;
		o_wr_select = 1'b0;
	end
	// Makes n selections on consecutive cycles, then scrambles the released address.
	task automatic select(input logic [2:0] dev, input logic [3:0] quads, input int n);
		for (int i = 0; i < n; i++) begin
			@(negedge i_clk_sys);
			o_strobe = 1'b1;
			o_addr = {dev, 3'h0, quads[2*i +: 2]};
		end
		@(negedge i_clk_sys);
		o_strobe = 1'b0;
		o_addr = ~o_addr;
	endtask
endmodule // quadrant_select_host
`default_nettype wire

// *** src/mq_flag_pkg.sv ***
package mq_flag_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int NUM_QUEUES   = 32;   // Queues in one device.
	localparam int BUS_BITS     = 8;    // Width of each flag bus.
	localparam int ADDR_BITS    = 8;    // Write queue address width.
	localparam int QUAD_BITS    = 2;    // Quadrant number width.
	localparam int DEV_BITS     = 3;    // Device number width.
	localparam int CNT_BITS     = 12;   // Per-queue word counter width.

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int DEV_LSB      = 5;    // Device number sits in the top three address bits.
	localparam int EOP_BIT      = 35;   // End-of-packet marker on the input word.
	localparam int SOP_BIT      = 34;   // Start-of-packet marker on both words.
	localparam logic [CNT_BITS-1:0] OFFSET_LOW  = 12'h0008; // Default offset, select low.
	localparam logic [CNT_BITS-1:0] OFFSET_HIGH = 12'h0080; // Default offset, select high.
	localparam logic [1:0] QUAD_RST = 2'h0; // Quadrant shown after reset.

	// ----------------------------------------------------------------
	// Cycle counts
	// ----------------------------------------------------------------
	localparam int FALL_CYCLES  = 2;    // Read to flag fall.
	localparam int PR_SET_EXTRA = 1;    // Extra stage for packet-ready after a write.

	// Input and output bus width setup.
	typedef enum logic [2:0] {
		W_36_36 = 3'h0,
		W_36_18 = 3'h1,
		W_36_9  = 3'h2,
		W_18_36 = 3'h3,
		W_9_36  = 3'h4
	} width_mode_t;

	// Almost-full bus operating mode.
	typedef enum logic [1:0] {
		AF_DIRECT = 2'b01,
		AF_POLLED = 2'b10
	} af_mode_t;

endpackage

// *** src/multiqueue_flag_status_logic.sv ***
`timescale 1ns/1ps
`default_nettype none

module multiqueue_flag_status_logic
	import mq_flag_pkg::*;
#(
	parameter int NQ = NUM_QUEUES,
	parameter int CW = CNT_BITS
) (
	// Clock, reset and enable.
	input  wire logic                                i_clk_sys,
	input  wire logic                                i_rst_b,
	input  wire logic                                i_ce,
	// Configuration; width mode and device number are used live, the rest is taken on the first enabled clock after master reset.
	input  wire logic                                i_default_offset_select,
	input  wire logic                                i_flag_bus_mode_select,
	input  wire mq_flag_pkg::width_mode_t            i_width_mode,
	input  wire logic [5:0]                          i_queues_configured,
	input  wire logic                                i_device_number_bit0,
	input  wire logic                                i_device_number_bit1,
	input  wire logic                                i_device_number_bit2,
	// Write port.
	input  wire logic                                i_wr_en,
	input  wire logic [4:0]                          i_wr_queue,
	input  wire logic                                i_wr_select,
	input  wire logic                                i_end_of_packet_marker,
	input  wire logic                                i_start_of_packet_marker,
	input  wire logic [mq_flag_pkg::ADDR_BITS-1:0]   i_write_queue_address,
	input  wire logic                                i_almost_full_quadrant_strobe,
	input  wire logic [NQ-1:0]                       i_almost_full_status,
	// Read port.
	input  wire logic                                i_rd_en,
	input  wire logic [4:0]                          i_rd_queue,
	input  wire logic                                i_rd_select,
	input  wire logic                                i_received_start_marker,
	// Discrete flags for the read queue, low active as on the pins.
	output logic                                     o_almost_empty_flag,
	output logic                                     o_packet_ready_flag,
	// Flag buses.
	output logic [mq_flag_pkg::BUS_BITS-1:0]         o_almost_empty_flag_bus,
	output logic [mq_flag_pkg::BUS_BITS-1:0]         o_packet_ready_flag_bus,
	output logic [mq_flag_pkg::BUS_BITS-1:0]         o_almost_full_flag_bus,
	output logic                                     o_almost_full_flag_bus_oe,
	output logic [mq_flag_pkg::QUAD_BITS-1:0]        o_quadrant
);
	import mq_flag_pkg::*;

	// ----------------------------------------------------------------
	// Configuration latched on the first clock after master reset
	// ----------------------------------------------------------------
	logic [CW-1:0]   offset_ff;       // Almost-empty offset n.
	af_mode_t        af_mode_ff;      // Almost-full bus mode.
	logic            few_queues_ff;   // Eight or fewer queues set up.
	logic            cfg_taken_ff;    // Configuration was sampled.
	logic [2:0]      dev_num;         // This device's static number.

	assign dev_num = {i_device_number_bit2, i_device_number_bit1, i_device_number_bit0};

	// Straps are caught by the clock while reset is released, never by the reset itself.
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cfg_taken_ff  <= 1'b0;
			offset_ff     <= OFFSET_LOW;
			af_mode_ff    <= AF_DIRECT;
			few_queues_ff <= 1'b0;
		end else if (i_ce && !cfg_taken_ff) begin
			cfg_taken_ff  <= 1'b1;
			offset_ff     <= i_default_offset_select ? OFFSET_HIGH : OFFSET_LOW;
			af_mode_ff    <= i_flag_bus_mode_select ? AF_POLLED : AF_DIRECT;
			few_queues_ff <= (i_queues_configured <= 6'(BUS_BITS));
		end
	end

	// ----------------------------------------------------------------
	// Threshold arithmetic
	// ----------------------------------------------------------------
	// Writes, in input words, needed before the flag reports not-almost-empty.
	function automatic logic [CW-1:0] ae_limit(input logic [CW-1:0] n,
	                                           input width_mode_t   wm,
	                                           input logic          shared);
		logic [CW-1:0] base;
		base = shared ? n + CW'(2) : n + CW'(1);
		case (wm)
			W_36_36: ae_limit = base;
			W_36_18: ae_limit = n + CW'(1);
			W_36_9:  ae_limit = n + CW'(1);
			W_18_36: ae_limit = base << 1;
			W_9_36:  ae_limit = base << 2;
			default: ae_limit = base;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Per-queue tracking
	// ----------------------------------------------------------------
	logic [CW-1:0] level      [NQ];   // Words held per queue.
	logic [CW-1:0] pkt_count  [NQ];   // Complete packets per queue.
	logic [NQ-1:0] sop_seen_ff;       // Start marker written, end not yet.
	logic [NQ-1:0] shared_ff;         // Both ports had queue at first word.
	logic [NQ-1:0] not_ae;            // Level reached its threshold.
	logic [NQ-1:0] wr_hit;            // Write to this queue this cycle.
	logic [NQ-1:0] rd_hit;            // Read of this queue this cycle.

	for (genvar q = 0; q < NQ; q++) begin : g_queue
		assign wr_hit[q] = i_wr_en && (i_wr_queue == 5'(q));
		assign rd_hit[q] = i_rd_en && (i_rd_queue == 5'(q));

		queue_level_tracker #(
			.CW (CW)
		) u_level (
			.i_clk_sys (i_clk_sys),
			.i_rst_b   (i_rst_b),
			.i_ce      (i_ce),
			.i_inc     (wr_hit[q]),
			.i_dec     (rd_hit[q]),
			.i_clr     (1'b0),
			.o_level   (level[q])
		);

		assign not_ae[q] = level[q] >= ae_limit(offset_ff, i_width_mode, shared_ff[q]);

		// Records whether both ports pointed at the queue when it was empty.
		always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
			if (!i_rst_b) begin
				shared_ff[q] <= 1'b0;
			end else if (i_ce && wr_hit[q] && level[q] == '0) begin
				shared_ff[q] <= (i_rd_queue == 5'(q));
			end
		end

		// Start marker arms the queue; end marker completes a packet.
		always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
			if (!i_rst_b) begin
				sop_seen_ff[q] <= 1'b0;
				pkt_count[q]   <= '0;
			end else if (i_ce) begin
				logic up;
				logic dn;
				up = wr_hit[q] && i_end_of_packet_marker && sop_seen_ff[q];
				dn = rd_hit[q] && i_received_start_marker && pkt_count[q] != '0;
				if (wr_hit[q] && i_start_of_packet_marker) begin
					sop_seen_ff[q] <= 1'b1;
				end else if (up) begin
					sop_seen_ff[q] <= 1'b0;
				end
				if (up && !dn) begin
					pkt_count[q] <= pkt_count[q] + CW'(1);
				end else if (dn && !up) begin
					pkt_count[q] <= pkt_count[q] - CW'(1);
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Flag timing pipelines, all on the read-side clock
	// ----------------------------------------------------------------
	logic [NQ-1:0] ae_d1_ff;   // First stage of almost-empty state.
	logic [NQ-1:0] ae_d2_ff;   // Second stage, cancels out of the almost-empty state.
	logic [NQ-1:0] pr_d1_ff;   // Packet-ready stages.
	logic [NQ-1:0] pr_d2_ff;
	logic [NQ-1:0] pr_d3_ff;
	logic [NQ-1:0] pr_now;     // Queue has a complete packet.
	logic [NQ-1:0] ae_state;   // Rise and fall both after one stage.
	logic [NQ-1:0] pr_state;   // Rise and fall both after two stages.

	for (genvar q = 0; q < NQ; q++) begin : g_pr
		assign pr_now[q] = pkt_count[q] != '0;
	end

	// A read shows after one cycle, as does a write that lifts the level.
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ae_d1_ff <= '0;
			ae_d2_ff <= '0;
			pr_d1_ff <= '0;
			pr_d2_ff <= '0;
			pr_d3_ff <= '0;
		end else if (i_ce) begin
			ae_d1_ff <= not_ae;
			ae_d2_ff <= ae_d1_ff;
			pr_d1_ff <= pr_now;
			pr_d2_ff <= pr_d1_ff;
			pr_d3_ff <= pr_d2_ff;
		end
	end

	// Almost-empty follows the first stage both ways; packet-ready follows the second.
	assign ae_state = ae_d1_ff & ae_d2_ff | ae_d1_ff & ~ae_d2_ff;
	assign pr_state = (pr_d2_ff & ~pr_d1_ff) | (pr_d1_ff & pr_d2_ff) | (pr_d2_ff & pr_d3_ff);

	// ----------------------------------------------------------------
	// Read-port outputs
	// ----------------------------------------------------------------
	logic [4:0] rd_q_ff;          // Queue currently selected for read.

	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rd_q_ff <= 5'h00;
		end else if (i_ce && i_rd_select) begin
			rd_q_ff <= i_rd_queue;
		end
	end

	// Discrete flags are active low: low means almost empty, low means ready.
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_almost_empty_flag <= 1'b0;
			o_packet_ready_flag <= 1'b1;
		end else if (i_ce) begin
			o_almost_empty_flag <= ae_state[rd_q_ff];
			o_packet_ready_flag <= ~pr_state[rd_q_ff];
		end
	end

	// Bus for read side shows quadrant zero; a read-port queue switch adds a cycle.
	logic [BUS_BITS-1:0] ae_bus_nxt; // Next almost-empty bus value.
	logic [BUS_BITS-1:0] pr_bus_nxt; // Next packet-ready bus value.

	assign ae_bus_nxt = ae_state[BUS_BITS-1:0];
	assign pr_bus_nxt = ~pr_state[BUS_BITS-1:0];

	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_almost_empty_flag_bus <= '0;
			o_packet_ready_flag_bus <= '1;
		end else if (i_ce && !i_rd_select) begin
			o_almost_empty_flag_bus <= ae_bus_nxt;
			o_packet_ready_flag_bus <= pr_bus_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Almost-full bus, direct mode
	// ----------------------------------------------------------------
	logic [QUAD_BITS-1:0] quad_ff;     // Latched quadrant number.
	logic                 owner_ff;    // This device drives the bus.
	logic                 dev_match;   // Strobed address names this device.

	assign dev_match = i_write_queue_address[ADDR_BITS-1:DEV_LSB] == dev_num;

	// Strobe naming this device takes the two low address bits; held until the next such strobe.
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			quad_ff  <= QUAD_RST;
			owner_ff <= 1'b1;
		end else if (i_ce && af_mode_ff == AF_DIRECT && i_almost_full_quadrant_strobe) begin
			owner_ff <= dev_match;
			if (dev_match) begin
				quad_ff <= i_write_queue_address[QUAD_BITS-1:0];
			end
		end
	end

	// Bus shows the new quadrant one cycle after the selecting edge.
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_almost_full_flag_bus    <= '1;
			o_almost_full_flag_bus_oe <= 1'b0;
			o_quadrant                <= QUAD_RST;
		end else if (i_ce) begin
			o_quadrant <= quad_ff;
			if (few_queues_ff) begin
				o_almost_full_flag_bus <= i_almost_full_status[BUS_BITS-1:0];
			end else begin
				o_almost_full_flag_bus <= i_almost_full_status[quad_ff*BUS_BITS +: BUS_BITS];
			end
			o_almost_full_flag_bus_oe <= cfg_taken_ff && af_mode_ff == AF_DIRECT && owner_ff;
		end
	end

endmodule // multiqueue_flag_status_logic

`default_nettype wire

// *** src/queue_level_tracker.sv ***
`timescale 1ns/1ps
`default_nettype none

// Keeps the fill level of one queue, counted in input-sized writes minus reads.
module queue_level_tracker
	import mq_flag_pkg::*;
#(
	parameter int CW = CNT_BITS
) (
	// Clock and reset.
	input  wire logic          i_clk_sys,
	input  wire logic          i_rst_b,
	input  wire logic          i_ce,
	// Events.
	input  wire logic          i_inc,
	input  wire logic          i_dec,
	input  wire logic          i_clr,
	// Level.
	output logic [CW-1:0]      o_level
);

	// ----------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------
	// A write and a read in one cycle cancel out.
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_level <= '0;
		end else if (i_ce) begin
			if (i_clr) begin
				o_level <= '0;
			end else if (i_inc && !i_dec) begin
				o_level <= o_level + CW'(1);
			end else if (i_dec && !i_inc && o_level != '0) begin
				o_level <= o_level - CW'(1);
			end
		end
	end

endmodule // queue_level_tracker

`default_nettype wire
